// [hdl/pfc_power_control.v]
// power feature control register with pull-up and session-edge logic
//
// Contract
// [R1] link never writes ones into reserved bits 7..5 and 1..0.
// [R2] pull-up bit 4 set in sync mode connects pull-up while vbus valid.
// [R3] uart mode keeps the d+ weak pull-up connected regardless of bit 4.
// [R4] fall enable bit 3 requests alt-int rxcmd on b-session falling edge.
// [R5] rise enable bit 2 requests alt-int rxcmd on b-session rising edge.
// [R6] all bits reset to zero, both edge notifications start disabled.
// [R7] readable at 3dh to 3fh; written 3dh, set 3eh, cleared 3fh.
// [R8] set ors byte in, clear clears ones, write replaces contents.
`timescale 1ns/1ns
`default_nettype none
`include "pfc_defs.vh"

module pfc_power_control
#(
  // widths and synchroniser depth
  parameter ADDR_W     = 6,
  parameter DATA_W     = 8,
  parameter SYNC_DEPTH = `PFC_SYNC_DEPTH
)
(
  // clock and reset
  input  wire              mclk,
  input  wire              rst_n,
  // register access from the ulpi register engine
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire              reg_wr,
  input  wire [DATA_W-1:0] reg_wdata,
  output reg  [DATA_W-1:0] reg_rdata,
  output wire              reg_hit,
  // analog status from pins
  input  wire              vbus_sess_valid_pin,
  input  wire              bsess_valid_pin,
  // mode from the ulpi state machine
  input  wire              uart_mode,
  // outputs to pad control and rxcmd logic
  output reg               dplus_weak_pullup_on,
  output reg               alt_int_req
);

  // pin slots in the synchroniser bank
  localparam PIN_VBUS  = 0;
  localparam PIN_BSESS = 1;
  localparam NUM_PINS  = 2;

  // register fields and reset value
  localparam BIT_PULLUP = `PFC_BIT_PULLUP;
  localparam BIT_FALL   = `PFC_BIT_FALL;
  localparam BIT_RISE   = `PFC_BIT_RISE;
  localparam [DATA_W-1:0] RESET_VALUE = `PFC_RESET;

  // register state
  reg  [DATA_W-1:0]   power_feature_control;
  wire [DATA_W-1:0]   next_power_feature_control;

  // field views
  wire                pullup_enable;
  wire                fall_enable;
  wire                rise_enable;

  // address decode
  reg                 addr_is_write;
  reg                 addr_is_set;
  reg                 addr_is_clear;
  wire                wr_write;
  wire                wr_set;
  wire                wr_clear;

  // synchronised pins and edge detect
  wire [NUM_PINS-1:0] pin_raw;
  wire [NUM_PINS-1:0] pin_safe;
  wire                vbus_valid;
  wire                bsess_now;
  reg                 bsess_prev;
  wire                bsess_rise;
  wire                bsess_fall;

  // feature terms
  reg                 next_pullup;
  reg                 next_alt;

  // one address matches at most; the chain keeps the decode plain
  always @*
  begin
    addr_is_write = 1'b0;
    addr_is_set   = 1'b0;
    addr_is_clear = 1'b0;
    if (reg_addr == `PFC_ADDR_WRITE)
      addr_is_write = 1'b1;
    else if (reg_addr == `PFC_ADDR_SET)
      addr_is_set = 1'b1;
    else if (reg_addr == `PFC_ADDR_CLEAR)
      addr_is_clear = 1'b1;
  end

  assign reg_hit = addr_is_write | addr_is_set | addr_is_clear; // [R7]

  assign wr_write = reg_wr & addr_is_write; // [R7]
  assign wr_set   = reg_wr & addr_is_set;   // [R7]
  assign wr_clear = reg_wr & addr_is_clear; // [R7]

  genvar b;
  generate
    for (b = 0; b < DATA_W; b = b + 1)
    begin : g_bit
      assign next_power_feature_control[b] =
        wr_write ? reg_wdata[b] :
        wr_set   ? (power_feature_control[b] | reg_wdata[b]) :
        wr_clear ? (power_feature_control[b] & ~reg_wdata[b]) :
                   power_feature_control[b]; // [R8]
    end
  endgenerate

  // reserved bits are stored as written; the link keeps them zero [R1]
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_feature_control <= RESET_VALUE; // [R6]
    end
    else
    begin
      power_feature_control <= next_power_feature_control;
    end
  end

  assign pullup_enable = power_feature_control[BIT_PULLUP];
  assign fall_enable   = power_feature_control[BIT_FALL];
  assign rise_enable   = power_feature_control[BIT_RISE];

  // read data is zero off the register's addresses
  always @*
  begin
    reg_rdata = {DATA_W{1'b0}};
    if (reg_hit)
      reg_rdata = power_feature_control; // [R7]
  end

  // comparator outputs are asynchronous to mclk
  assign pin_raw[PIN_VBUS]  = vbus_sess_valid_pin;
  assign pin_raw[PIN_BSESS] = bsess_valid_pin;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p = p + 1)
    begin : g_sync
      reg [SYNC_DEPTH-1:0] stage;

      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage <= {SYNC_DEPTH{1'b0}};
        end
        else
        begin
          stage <= {stage[SYNC_DEPTH-2:0], pin_raw[p]};
        end
      end

      // only the last stage leaves the bank
      assign pin_safe[p] = stage[SYNC_DEPTH-1];
    end
  endgenerate

  assign vbus_valid = pin_safe[PIN_VBUS];
  assign bsess_now  = pin_safe[PIN_BSESS];

  // resets low like the idle pin, so no false edge follows reset
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bsess_prev <= 1'b0;
    end
    else
    begin
      bsess_prev <= bsess_now;
    end
  end

  assign bsess_rise = bsess_now & ~bsess_prev;
  assign bsess_fall = ~bsess_now & bsess_prev;

  // uart mode overrides the enable bit
  always @*
  begin
    next_pullup = uart_mode; // [R3]
    if (pullup_enable && vbus_valid)
      next_pullup = 1'b1; // [R2]
  end

  // each edge gated by its own enable
  always @*
  begin
    next_alt = 1'b0;
    if (bsess_fall && fall_enable)
      next_alt = 1'b1; // [R4]
    if (bsess_rise && rise_enable)
      next_alt = 1'b1; // [R5]
  end

  // registered so the pad control never glitches on a mode change
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dplus_weak_pullup_on <= 1'b0;
    end
    else
    begin
      dplus_weak_pullup_on <= next_pullup;
    end
  end

  // one cycle per synchronised edge
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alt_int_req <= 1'b0;
    end
    else
    begin
      alt_int_req <= next_alt;
    end
  end

endmodule // pfc_power_control
`default_nettype wire

// [inc/pfc_defs.vh]
// constants for the phy power feature control register
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
`define PFC_ADDR_WRITE   6'h3d
`define PFC_ADDR_SET     6'h3e
`define PFC_ADDR_CLEAR   6'h3f
`define PFC_RESET        8'h00
`define PFC_BIT_PULLUP   4
`define PFC_BIT_FALL     3
`define PFC_BIT_RISE     2
`define PFC_USED_MASK    8'h1c
`define PFC_SYNC_DEPTH   2
`endif

// [bench/pfc_link.sv]
// link model issuing register accesses on falling edges
`timescale 1ns/1ns
`default_nettype none
`include "pfc_defs.vh"
module pfc_link(input wire logic mclk, output var logic [5:0] reg_addr = 0,
  output var logic reg_wr = 0, output var logic [7:0] reg_wdata = 0);
  task acc(logic [5:0] a, logic [7:0] v, logic w);
    @(negedge mclk) {reg_addr, reg_wr} = {a, w};
    reg_wdata = w ? v & `PFC_USED_MASK : ~reg_wdata;
    @(negedge mclk) reg_wr = 0;
  endtask
endmodule // pfc_link
`default_nettype wire

// [bench/pfc_assertions.sv]
// port assertions for the power feature control register
`timescale 1ns/1ns
`default_nettype none
module pfc_assertions(input wire logic mclk, rst_n, reg_wr, reg_hit,
  uart_mode, dplus_weak_pullup_on, bsess_valid_pin, alt_int_req,
  input wire logic [5:0] reg_addr, input wire logic [7:0] reg_wdata,
  reg_rdata);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_hit_decode: assert property (reg_hit == (reg_addr > 6'h3c))
    else $error("hit flag wrong");
  a_set_or: assert property (reg_wr && reg_addr == 6'h3e ##1 reg_hit
    |-> reg_rdata == ($past(reg_rdata) | $past(reg_wdata)))
    else $error("set wrong");
  a_uart_pullup: assert property (uart_mode |=> dplus_weak_pullup_on)
    else $error("uart pullup off");
  a_pullup_off: assert property (!uart_mode && !reg_wr && reg_hit
    && !reg_rdata[4] |=> !dplus_weak_pullup_on) else $error("pullup on");
  cover property (reg_wr && reg_hit);
  cover property (uart_mode ##1 dplus_weak_pullup_on);
  a_miss_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
    else $error("read data off address not zero");
  a_alt_edge: assert property (alt_int_req |->
    $past(bsess_valid_pin, 3) != $past(bsess_valid_pin, 4))
    else $error("alt pulse without session edge");
  cover property (!reg_hit);
  cover property (alt_int_req);
endmodule // pfc_assertions
bind pfc_power_control pfc_assertions chk(.*);
`default_nettype wire

// [bench/tb_top.sv]
// bench for the power feature control register
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk = 0, rst_n = 0, vbus_sess_valid_pin = 0, bsess_valid_pin = 0;
  logic uart_mode = 0, reg_hit, reg_wr, dplus_weak_pullup_on, alt_int_req;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int n_fail = 0, compares = 0, n;
  initial forever #5 mclk = ~mclk;
  pfc_link link(.*);
  pfc_power_control DUT(.*);
  task ck(string s, logic [7:0] e, g);
    compares++;
    if (g !== e) $display("unexpected %s exp %h got %h", s, e, g);
    n_fail += g !== e;
  endtask
  task t(logic [5:0] a, logic [7:0] v, logic w, logic [7:0] e);
    link.acc(a, v, w);
    ck("rdata", e, reg_rdata);
  endtask
  // session edge, then count pulses over a window
  task b(logic v, logic [7:0] e);
    bsess_valid_pin = v;
    n = 0;
    repeat (6) @(negedge mclk) n += alt_int_req;
    ck("alt", e, n[7:0]);
  endtask
  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge mclk);
    rst_n = 1;
    t(6'h3d, 0, 0, 0);
    t(6'h3d, 8'hff, 1, 8'h1c);
    t(6'h3f, 8'h08, 1, 8'h14);
    t(6'h3e, 8'h08, 1, 8'h1c);
    t(6'h10, 0, 0, 0);
    b(1, 1);
    b(0, 1);
    t(6'h3f, 8'h0c, 1, 8'h10);
    vbus_sess_valid_pin = 1;
    b(1, 0);
    ck("pullup", 1, dplus_weak_pullup_on);
    t(6'h3d, 0, 1, 0);
    uart_mode = 1;
    b(0, 0);
    ck("pullup", 1, dplus_weak_pullup_on);
    t(6'h3e, 8'h1c, 1, 8'h1c);
    uart_mode = 0;
    rst_n = 0;
    repeat (2) @(negedge mclk);
    rst_n = 1;
    t(6'h3d, 0, 0, 0);
    ck("pullup", 0, dplus_weak_pullup_on);
    summarize;
  end
endmodule // tb_top
`default_nettype wire
